// ==== frt_regs.svh ====
// Purpose: register offsets, fields, reset values and timing counts of the frequency/trigger block
// Assumes: APB, 32-bit data, one aligned word per register, 100 MHz clock
// Notes: definitions only
`ifndef FRT_REGS_SVH
`define FRT_REGS_SVH
// =====================================================================
// register byte offsets
`define FRT_CTRL_OFS 12'h000
`define FRT_GATE_OFS 12'h004
`define FRT_FREQ_OFS 12'h008
`define FRT_PRE_OFS 12'h00C
`define FRT_POST_OFS 12'h010
`define FRT_DLY_OFS 12'h014
`define FRT_STAT_OFS 12'h018
`define FRT_CLR_OFS 12'h01C
`define FRT_IEN_OFS 12'h020
`define FRT_CNT_OFS 12'h024
`define FRT_SAMP_OFS 12'h028
// =====================================================================
// control fields
`define FRT_CTRL_ENABLE 0
`define FRT_CTRL_BIDIR 1
`define FRT_CTRL_QUAL 2
`define FRT_CTRL_EXTEN 3
`define FRT_CTRL_EXTFALL 4
`define FRT_CTRL_ARM 5
`define FRT_CTRL_SWTRIG 6
// top bit of the 33-bit gate length, so the gate can reach 50 s
`define FRT_CTRL_GATEHI 7
// status / interrupt fields
`define FRT_ST_GATE 0
`define FRT_ST_TRIG 1
`define FRT_ST_DONE 2
`define FRT_ST_DROP 3
// =====================================================================
// reset values
`define FRT_CTRL_RST 32'h0000_0000
`define FRT_GATE_RST 32'h0000_0064
`define FRT_SAMP_RST 32'h0000_0032
// =====================================================================
// timing: clock 100 MHz
`define FRT_CLK_HZ 100000000
`define FRT_TRIG_RATE_HZ 400
`define FRT_TRIG_HOLDOFF_CYC (`FRT_CLK_HZ / `FRT_TRIG_RATE_HZ)
`define FRT_GATE_MAX_S 50
`define FRT_GATE_MAX_CYC (64'd50 * 64'd100000000)
// clock cycles per microsecond of trigger delay
`define FRT_CYC_PER_US 64'd100
`define FRT_DELAY_MAX_S 1000
`define FRT_DELAY_MAX_CYC (64'd1000 * 64'd100000000)
`endif

// ==== frt_pkg.sv ====
// Purpose: types of the frequency/trigger block
// Assumes: nothing
// Notes: constants live in frt_regs.svh
package frt_pkg;
   // =====================================================================
   // acquisition sequencer states
   typedef enum logic [2:0] {
      FRT_IDLE = 3'b000,
      FRT_PRE = 3'b001,
      FRT_WAIT = 3'b010,
      FRT_DELAY = 3'b011,
      FRT_POST = 3'b100
   } frt_state_t;
endpackage

// ==== frt_freq_trig.sv ====
// Purpose: frequency/RPM measurement channel and acquisition trigger logic
// Assumes: APB slave, one 100 MHz clock, sample rate from an internal divider
// Notes: result is signed edge count per gate; gate length counted in clock cycles
`timescale 1ns/100ps
`default_nettype none
`include "frt_regs.svh"

module frt_freq_trig #(
   parameter int MEM_DEPTH = 32'h0400_0000,
   parameter int HOLDOFF = `FRT_TRIG_HOLDOFF_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // sensor pins
   input wire logic pulseIn,
   input wire logic dirIn,
   // mainframe trigger line
   input wire logic extTrigIn,
   // acquisition side
   output logic trigOut,
   output logic recording,
   output logic irq
);
   import frt_pkg::*;

   // =====================================================================
   // parameter checks
   // refused at elaboration, before any logic exists
   if (MEM_DEPTH < 1 || HOLDOFF < 1) begin : g_badParam
      $error("frt_freq_trig: bad parameter");
   end

   // =====================================================================
   // pin synchronisers, two stages each
   logic [2:0] syncA_r; // first stage, read only by second
   logic [2:0] syncB_r; // second stage
   logic [1:0] hist_r; // previous pulse/ext levels for edges
   always_ff @(posedge clock) begin
      if (srst) begin
         syncA_r <= 3'h0;
         syncB_r <= 3'h0;
         hist_r <= 2'h0;
      end else begin
         syncA_r <= {extTrigIn, dirIn, pulseIn};
         syncB_r <= syncA_r;
         hist_r <= {syncB_r[2], syncB_r[0]};
      end
   end
   logic pulseS, dirS, extS;
   assign pulseS = syncB_r[0];
   assign dirS = syncB_r[1];
   assign extS = syncB_r[2];
   logic pulseEdge, extEdge;
   // 100 MHz sampling resolves 100 ns pulses at 5 MHz
   assign pulseEdge = pulseS & ~hist_r[0];
   logic fallSel;
   assign extEdge = fallSel ? (hist_r[1] & ~extS) : (extS & ~hist_r[1]);

   // =====================================================================
   // registers
   logic [31:0] ctrl_r, ctrl_nxt; // control bits
   logic [31:0] gate_r, gate_nxt; // gate length in cycles
   logic [31:0] samp_r, samp_nxt; // sample period in cycles
   logic [31:0] pre_r, pre_nxt; // pre-trigger samples
   logic [31:0] post_r, post_nxt; // post-trigger samples
   logic [63:0] dly_r, dly_nxt; // trigger delay in cycles (low word read back)
   logic [3:0] ien_r, ien_nxt; // interrupt enables
   logic [3:0] stat_r, stat_nxt; // sticky status
   logic [31:0] freq_r, freq_nxt; // signed result
   logic [31:0] edges_r, edges_nxt; // edges in current gate
   logic [32:0] gcnt_r, gcnt_nxt; // gate cycle counter, 33 bits for 50 s
   logic [31:0] scnt_r, scnt_nxt; // sample divider
   logic [31:0] acnt_r, acnt_nxt; // sample count in phase
   logic [63:0] dcnt_r, dcnt_nxt; // delay counter
   logic [31:0] hold_r, hold_nxt; // trigger holdoff
   logic trig_r, trig_nxt;
   frt_state_t st_r, st_nxt;
   assign fallSel = ctrl_r[`FRT_CTRL_EXTFALL];
   logic [32:0] gateLen; // gate length with its control top bit
   assign gateLen = {ctrl_r[`FRT_CTRL_GATEHI], gate_r};

   // apb decode: zero wait state
   logic wrEn, rdEn;
   assign wrEn = psel & penable & pwrite;
   assign rdEn = psel & penable & ~pwrite;
   assign pready = 1'b1;
   logic mapped;
   always_comb begin
      case (paddr)
         `FRT_CTRL_OFS, `FRT_GATE_OFS, `FRT_FREQ_OFS, `FRT_PRE_OFS, `FRT_POST_OFS, `FRT_DLY_OFS,
         `FRT_STAT_OFS, `FRT_CLR_OFS, `FRT_IEN_OFS, `FRT_CNT_OFS, `FRT_SAMP_OFS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~mapped;

   // =====================================================================
   // sample clock enable
   logic sampTick;
   assign sampTick = (scnt_r == 32'h0000_0000);

   // triggers and qualifier
   logic detHit, qualOk, trigReq, trigAcc;
   // internal detector: pulse edge; either trigger source or qualifier
   assign detHit = ctrl_r[`FRT_CTRL_QUAL] ? 1'b0 : pulseEdge;
   assign qualOk = ctrl_r[`FRT_CTRL_QUAL] ? pulseS : 1'b1;
   assign trigReq = (detHit | (extEdge & ctrl_r[`FRT_CTRL_EXTEN])
      | (wrEn & paddr == `FRT_CTRL_OFS & pwdata[`FRT_CTRL_SWTRIG])) & qualOk;
   assign trigAcc = trigReq & (hold_r == 32'h0000_0000) & (st_r == FRT_WAIT);

   // =====================================================================
   // next-state logic
   always_comb begin
      ctrl_nxt = ctrl_r;
      gate_nxt = gate_r;
      samp_nxt = samp_r;
      pre_nxt = pre_r;
      post_nxt = post_r;
      dly_nxt = dly_r;
      ien_nxt = ien_r;
      stat_nxt = stat_r;
      freq_nxt = freq_r;
      edges_nxt = edges_r;
      gcnt_nxt = gcnt_r;
      scnt_nxt = (sampTick) ? samp_r - 32'h0000_0001 : scnt_r - 32'h0000_0001;
      acnt_nxt = acnt_r;
      dcnt_nxt = dcnt_r;
      hold_nxt = (hold_r != 32'h0000_0000) ? hold_r - 32'h0000_0001 : hold_r;
      trig_nxt = 1'b0;
      st_nxt = st_r;
      // register writes
      if (wrEn) begin
         case (paddr)
            `FRT_CTRL_OFS: ctrl_nxt = {24'h00_0000, pwdata[`FRT_CTRL_GATEHI], 1'b0, pwdata[5:0]};
            // one cycle minimum; 32 bits alone stop near 43 s, the control top bit reaches 50 s
            `FRT_GATE_OFS: gate_nxt = (pwdata == 32'h0000_0000) ? 32'h0000_0001 : pwdata;
            `FRT_SAMP_OFS: samp_nxt = (pwdata == 32'h0000_0000) ? 32'h0000_0001 : pwdata;
            `FRT_PRE_OFS: pre_nxt = (pwdata > MEM_DEPTH) ? MEM_DEPTH : pwdata;
            `FRT_POST_OFS: post_nxt = (pwdata > MEM_DEPTH) ? MEM_DEPTH : pwdata;
            `FRT_DLY_OFS: dly_nxt = {32'h0000_0000, pwdata} * `FRT_CYC_PER_US; // us units
            `FRT_IEN_OFS: ien_nxt = pwdata[3:0];
            `FRT_CLR_OFS: stat_nxt = stat_r & ~pwdata[3:0];
            default: ;
         endcase
      end
      // frequency gate: edges per gate, sign from direction
      if (ctrl_r[`FRT_CTRL_ENABLE]) begin
         if (gcnt_r + 33'h0_0000_0001 >= gateLen) begin
            // result signed only in bidirectional mode
            if (ctrl_r[`FRT_CTRL_BIDIR] & dirS) begin
               freq_nxt = 32'h0000_0000 - (edges_r + {31'h0, pulseEdge});
            end else begin
               freq_nxt = edges_r + {31'h0, pulseEdge};
            end
            edges_nxt = 32'h0000_0000;
            gcnt_nxt = 33'h0_0000_0000;
            stat_nxt[`FRT_ST_GATE] = 1'b1;
         end else begin
            edges_nxt = edges_r + {31'h0, pulseEdge};
            gcnt_nxt = gcnt_r + 33'h0_0000_0001;
         end
      end else begin
         edges_nxt = 32'h0000_0000;
         gcnt_nxt = 33'h0_0000_0000;
      end
      // acquisition sequencer
      case (st_r)
         FRT_IDLE: begin
            if (ctrl_r[`FRT_CTRL_ARM]) begin
               acnt_nxt = 32'h0000_0000;
               st_nxt = FRT_PRE;
            end
         end
         FRT_PRE: begin
            if (acnt_r >= pre_r) begin
               st_nxt = FRT_WAIT;
            end else if (sampTick) begin
               acnt_nxt = acnt_r + 32'h0000_0001;
            end
         end
         FRT_WAIT: begin
            if (trigAcc) begin
               hold_nxt = HOLDOFF;
               dcnt_nxt = dly_r;
               stat_nxt[`FRT_ST_TRIG] = 1'b1;
               st_nxt = FRT_DELAY;
            end
         end
         FRT_DELAY: begin
            if (dcnt_r == 64'h0000_0000_0000_0000) begin
               trig_nxt = 1'b1;
               acnt_nxt = 32'h0000_0000;
               st_nxt = FRT_POST;
            end else begin
               dcnt_nxt = dcnt_r - 64'h0000_0000_0000_0001;
            end
         end
         FRT_POST: begin
            if (acnt_r >= post_r) begin
               stat_nxt[`FRT_ST_DONE] = 1'b1;
               ctrl_nxt[`FRT_CTRL_ARM] = 1'b0;
               st_nxt = FRT_IDLE;
            end else if (sampTick) begin
               acnt_nxt = acnt_r + 32'h0000_0001;
            end
         end
         default: st_nxt = FRT_IDLE;
      endcase
      // trigger refused by holdoff or state
      if (trigReq & ~trigAcc) begin
         stat_nxt[`FRT_ST_DROP] = 1'b1;
      end
   end

   // =====================================================================
   // registers
   always_ff @(posedge clock) begin
      if (srst) begin
         ctrl_r <= `FRT_CTRL_RST;
         gate_r <= `FRT_GATE_RST;
         samp_r <= `FRT_SAMP_RST;
         pre_r <= 32'h0000_0000;
         post_r <= 32'h0000_0000;
         dly_r <= 64'h0000_0000_0000_0000;
         ien_r <= 4'h0;
         stat_r <= 4'h0;
         freq_r <= 32'h0000_0000;
         edges_r <= 32'h0000_0000;
         gcnt_r <= 33'h0_0000_0000;
         scnt_r <= 32'h0000_0000;
         acnt_r <= 32'h0000_0000;
         dcnt_r <= 64'h0000_0000_0000_0000;
         hold_r <= 32'h0000_0000;
         trig_r <= 1'b0;
         st_r <= FRT_IDLE;
      end else begin
         ctrl_r <= ctrl_nxt;
         gate_r <= gate_nxt;
         samp_r <= samp_nxt;
         pre_r <= pre_nxt;
         post_r <= post_nxt;
         dly_r <= dly_nxt;
         ien_r <= ien_nxt;
         stat_r <= stat_nxt;
         freq_r <= freq_nxt;
         edges_r <= edges_nxt;
         gcnt_r <= gcnt_nxt;
         scnt_r <= scnt_nxt;
         acnt_r <= acnt_nxt;
         dcnt_r <= dcnt_nxt;
         hold_r <= hold_nxt;
         trig_r <= trig_nxt;
         st_r <= st_nxt;
      end
   end

   // =====================================================================
   // read mux
   always_comb begin
      prdata = 32'h0000_0000;
      if (rdEn) begin
         case (paddr)
            `FRT_CTRL_OFS: prdata = ctrl_r;
            `FRT_GATE_OFS: prdata = gate_r;
            `FRT_FREQ_OFS: prdata = freq_r;
            `FRT_PRE_OFS: prdata = pre_r;
            `FRT_POST_OFS: prdata = post_r;
            `FRT_DLY_OFS: prdata = dly_r[31:0];
            `FRT_STAT_OFS: prdata = {25'h0, st_r, stat_r};
            `FRT_IEN_OFS: prdata = {28'h0, ien_r};
            `FRT_CNT_OFS: prdata = edges_r;
            `FRT_SAMP_OFS: prdata = samp_r;
            default: prdata = 32'h0000_0000;
         endcase
      end
   end

   // outputs
   assign trigOut = trig_r;
   assign recording = (st_r != FRT_IDLE);
   assign irq = |(stat_r & ien_r);
endmodule
`default_nettype wire

// ==== frt_sensor_model.sv ====
// Purpose: sensor pulse, direction and mainframe trigger line model
// Assumes: one clock, bench sets the controls
// Notes: pulse stands low while halfCyc is zero
`timescale 1ns/100ps
`default_nettype none
// =====================================
module frt_sensor_model (
   // clock and controls
   input wire logic clock,
   input wire logic srst,
   input wire logic [7:0] halfCyc,
   input wire logic dirLvl,
   input wire logic fallEdge,
   input wire logic fire,
   // pins
   output logic pulseIn,
   output logic dirIn,
   output logic extTrigIn
);
   logic [7:0] cnt_r; // half period count
   logic [5:0] wid_r; // trigger pulse width, 500 ns
   logic wrap; // half period ends
   assign wrap = (cnt_r + 8'h01 >= halfCyc);
   // three pins, pulse train, direction level and trigger line
   always_ff @(posedge clock) begin
      cnt_r <= (srst || halfCyc == 8'h00 || wrap) ? 8'h00 : cnt_r + 8'h01;
      pulseIn <= (srst || halfCyc == 8'h00) ? 1'b0 : pulseIn ^ wrap;
      dirIn <= dirLvl;
      wid_r <= srst ? 6'h00 : fire ? 6'h32 : (wid_r != 6'h00) ? wid_r - 6'h01 : 6'h00;
      extTrigIn <= fallEdge ^ (wid_r != 6'h00); // edge sense set per mainframe
   end
endmodule
`default_nettype wire

// ==== frt_freq_trig_monitor.sv ====
// Purpose: port checker of the frequency/trigger block
// Assumes: one clock, srst synchronous
// Notes: bound to every frt_freq_trig
`timescale 1ns/100ps
`default_nettype none
// =====================================
module frt_freq_trig_monitor #(parameter int HOLDOFF = 10) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // acquisition
   input wire logic trigOut,
   input wire logic recording
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   int gap_r; // cycles since last trigger
   // spacing counter, preset to HOLDOFF by reset
   always_ff @(posedge clock) begin
      gap_r <= srst ? HOLDOFF : trigOut ? 1 : gap_r + 1;
   end
   sequence s_access;
      psel && penable;
   endsequence
   chk_ready_zero: assert property (s_access |-> pready) else $error("pready low in access");
   chk_err_place: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
   chk_rdata_idle: assert property (!(psel && penable) |-> prdata == 32'h0000_0000) else $error("prdata not 0");
   chk_unmapped_err: assert property (psel && penable && paddr > 12'h028 |-> pslverr) else $error("no pslverr");
   chk_mapped_ok: assert property (psel && penable && paddr <= 12'h028 && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("pslverr on mapped");
   chk_trig_single: assert property (trigOut |=> !trigOut) else $error("trigOut too long");
   chk_trig_rec: assert property (trigOut |-> recording) else $error("trigOut while idle");
   chk_trig_rate: assert property (trigOut |-> gap_r >= HOLDOFF) else $error("triggers too close");
   chk_rec_start: assert property ($rose(recording) |-> $past(psel && penable && pwrite)
      || $past(psel && penable && pwrite, 2))
      else $error("recording without write");
   chk_reset_quiet: assert property (disable iff (1'b0) srst |=> !trigOut && !recording)
      else $error("busy after reset");
endmodule
bind frt_freq_trig frt_freq_trig_monitor #(.HOLDOFF(HOLDOFF)) u_mon (.clock(clock), .srst(srst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .trigOut(trigOut), .recording(recording));
`default_nettype wire

// ==== frt_freq_trig_bench.sv ====
// Purpose: self-checking bench of the frequency/trigger block
// Assumes: HOLDOFF shortened to 10 cycles
// Notes: pins come from frt_sensor_model
`timescale 1ns/100ps
`default_nettype none
`include "frt_regs.svh"
// =====================================
module frt_freq_trig_bench;
   import frt_pkg::*;
   typedef struct {logic [11:0] a; logic [31:0] d; logic e;} frt_row_t; // address or control, value, flag
   logic clock, srst, psel, penable, pwrite, pready, pslverr, err;
   logic pulseIn, dirIn, extTrigIn, trigOut, recording, irq, dirLvl, fallEdge, fire;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] halfCyc;
   int failures = 0, n_tests = 0, cyc = 0, nTrig = 0, lat;
   // reset values and unmapped place
   frt_row_t rows[7] = '{'{`FRT_CTRL_OFS, `FRT_CTRL_RST, 1'b0}, '{`FRT_GATE_OFS, `FRT_GATE_RST, 1'b0},
      '{`FRT_SAMP_OFS, `FRT_SAMP_RST, 1'b0}, '{`FRT_FREQ_OFS, 32'h0000_0000, 1'b0},
      '{`FRT_STAT_OFS, 32'h0000_0000, 1'b0}, '{`FRT_IEN_OFS, 32'h0000_0000, 1'b0}, '{12'h100, 32'h0000_0000, 1'b1}};
   // control, expected result, direction; 5 edges per 100-cycle gate
   frt_row_t fq[3] = '{'{12'h001, 32'h0000_0005, 1'b1}, '{12'h003, 32'hFFFF_FFFB, 1'b1},
      '{12'h003, 32'h0000_0005, 1'b0}};
   frt_freq_trig #(.HOLDOFF(10)) DUT (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pulseIn(pulseIn), .dirIn(dirIn), .extTrigIn(extTrigIn), .trigOut(trigOut), .recording(recording), .irq(irq));
   frt_sensor_model u_sens (.clock(clock), .srst(srst), .halfCyc(halfCyc), .dirLvl(dirLvl), .fallEdge(fallEdge),
      .fire(fire), .pulseIn(pulseIn), .dirIn(dirIn), .extTrigIn(extTrigIn));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // trigger count and hang guard
   always @(posedge clock) begin
      cyc++;
      if (trigOut === 1'b1) nTrig++;
      if (cyc == 20000) begin
         failures++;
         $display("FAIL t=%0t timeout", $time);
         results();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock) penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic results();
      $display("comparisons %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      {srst, psel, penable, pwrite, dirLvl, fallEdge, fire} = 7'h01 << 6;
      {paddr, pwdata, halfCyc} = '0;
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      foreach (rows[i]) begin
         apb(1'b0, rows[i].a, 32'h0000_0000);
         chk(rd, rows[i].d);
         chk(32'(err), 32'(rows[i].e));
      end
      $display("test registers done");
      halfCyc <= 8'h0A;
      foreach (fq[i]) begin
         dirLvl <= fq[i].e;
         apb(1'b1, `FRT_CTRL_OFS, {20'h0_0000, fq[i].a});
         repeat (350) @(posedge clock);
         apb(1'b0, `FRT_FREQ_OFS, 32'h0000_0000);
         chk(rd, fq[i].d);
      end
      $display("test frequency done");
      chk(32'(irq), 32'h0000_0000); // enable still clear, so masked
      apb(1'b1, `FRT_IEN_OFS, 32'h0000_0001);
      @(posedge clock);
      chk(32'(irq), 32'h0000_0001);
      apb(1'b1, `FRT_CTRL_OFS, 32'h0000_0000);
      apb(1'b1, `FRT_CLR_OFS, 32'h0000_000F);
      @(posedge clock);
      chk(32'(irq), 32'h0000_0000);
      $display("test interrupt done");
      halfCyc <= 8'h00;
      apb(1'b1, `FRT_PRE_OFS, 32'h0000_0000);
      apb(1'b1, `FRT_POST_OFS, 32'h0000_0002);
      for (int k = 0; k < 2; k++) begin
         fallEdge <= k[0];
         apb(1'b1, `FRT_DLY_OFS, 32'(k));
         apb(1'b1, `FRT_CTRL_OFS, 32'h0000_0028 | 32'(k << 4));
         repeat (20) @(posedge clock);
         fire <= 1'b1;
         @(posedge clock) fire <= 1'b0;
         for (lat = 0; lat < 400 && trigOut !== 1'b1; lat++) @(posedge clock);
         chk(32'(lat >= 100 * k && lat <= 100 * k + 100 + `FRT_SAMP_RST), 32'h0000_0001);
         for (lat = 0; lat < 1000 && recording !== 1'b0; lat++) @(posedge clock);
         apb(1'b0, `FRT_STAT_OFS, 32'h0000_0000);
         chk(32'(rd[2:1]), 32'h0000_0003);
         apb(1'b1, `FRT_CLR_OFS, 32'h0000_000F);
      end
      $display("test trigger done");
      apb(1'b1, `FRT_CTRL_OFS, 32'h0000_0020);
      apb(1'b1, `FRT_CTRL_OFS, 32'h0000_0060);
      apb(1'b1, `FRT_CTRL_OFS, 32'h0000_0060);
      apb(1'b0, `FRT_STAT_OFS, 32'h0000_0000);
      chk(32'(rd[3]), 32'h0000_0001);
      srst <= 1'b1;
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      chk(32'({recording, trigOut, irq}), 32'h0000_0000);
      // gate floor, gate top bit, memory clamp and delay scaling
      apb(1'b1, `FRT_GATE_OFS, 32'h0000_0000);
      apb(1'b0, `FRT_GATE_OFS, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      apb(1'b1, `FRT_CTRL_OFS, 32'h0000_0080);
      apb(1'b0, `FRT_CTRL_OFS, 32'h0000_0000);
      chk(rd, 32'h0000_0080);
      apb(1'b1, `FRT_PRE_OFS, 32'hFFFF_FFFF);
      apb(1'b0, `FRT_PRE_OFS, 32'h0000_0000);
      chk(rd, 32'h0400_0000);
      apb(1'b1, `FRT_DLY_OFS, 32'h0000_0003);
      apb(1'b0, `FRT_DLY_OFS, 32'h0000_0000);
      chk(rd, 32'h0000_012C);
      $display("test drop and reset done");
      lat = nTrig;
      apb(1'b1, `FRT_PRE_OFS, 32'h0000_0000);
      apb(1'b1, `FRT_CTRL_OFS, 32'h0000_0024);
      apb(1'b1, `FRT_CTRL_OFS, 32'h0000_0064);
      repeat (300) @(posedge clock);
      chk(32'(nTrig - lat), 32'h0000_0000);
      $display("test qualifier done");
      results();
   end
endmodule
`default_nettype wire
